// ### usb_endpoint_out_fifo_ctrl_test.sv
// ==========================================================
// Self-checking bench for the endpoint controller
module usb_endpoint_out_fifo_ctrl_test
    import usb_ep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, irq, out_token, rx_valid, rx_done, rx_bad, proto_err;
    logic ep0_rx_valid, ep0_setup, ep0_data_in, hs_valid, tx_valid, tx_ep0;
    logic ep0_dir_in, usb_clk_en, usb_rst_n;
    logic [7:0] rx_byte, tx_byte;
    logic [1:0] hs_code;
    logic [6:0] in_max_bytes, out_max_bytes;
    logic [4:0] ep0_max_bytes;
    int errors = 0, comparisons = 0, hs_n = 0;
    logic [31:0] q;
    // Table row: register, value written, value read back, port value
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;
                    logic [6:0] p;} row_t;
    row_t rows[11] = '{'{ADR_IN_MAX, 8'h00, 8'h00, 7'h00},
        '{ADR_IN_MAX, 8'h03, 8'h03, 7'h18}, '{ADR_IN_MAX, 8'h08, 8'h08, 7'h40},
        '{ADR_OUT_MAX, 8'h01, 8'h01, 7'h08}, '{ADR_OUT_MAX, 8'h08, 8'h08, 7'h40},
        '{ADR_EP0_MAX, 8'h01, 8'h01, 7'h10}, '{ADR_EP0_MAX, 8'h00, 8'h00, 7'h08},
        '{ADR_SYS_CTRL, 8'h01, 8'h01, 7'h01}, '{ADR_SYS_CTRL, 8'h02, 8'h02, 7'h02},
        '{ADR_SYS_CTRL, 8'h03, 8'h03, 7'h03}, '{8'h3C, 8'h55, 8'h00, 7'h00}};
    always #2.5 mclk = ~mclk;
    usb_ep_ctrl i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq(irq), .out_token(out_token),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_done(rx_done),
        .rx_bad(rx_bad), .proto_err(proto_err), .ep0_rx_valid(ep0_rx_valid),
        .ep0_setup(ep0_setup), .ep0_data_in(ep0_data_in),
        .hs_valid(hs_valid), .hs_code(hs_code), .tx_valid(tx_valid),
        .tx_ep0(tx_ep0), .tx_byte(tx_byte), .ep0_dir_in(ep0_dir_in),
        .in_max_bytes(in_max_bytes), .out_max_bytes(out_max_bytes),
        .ep0_max_bytes(ep0_max_bytes), .usb_clk_en(usb_clk_en),
        .usb_rst_n(usb_rst_n));
    usb_host_model i_host (.mclk(mclk), .out_token(out_token),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_done(rx_done),
        .rx_bad(rx_bad), .proto_err(proto_err), .ep0_rx_valid(ep0_rx_valid),
        .ep0_setup(ep0_setup), .ep0_data_in(ep0_data_in),
        .hs_valid(hs_valid), .hs_code(hs_code), .tx_valid(tx_valid),
        .tx_ep0(tx_ep0), .tx_byte(tx_byte));
    // ==========================================================
    // Verdict and the single place the run ends
    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; a missing ack is cut short by the bound
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            errors++;
            stop_test();
        end
        q = wb_dat_o;
        // Request stands through the edge that samples ack high
        @(posedge mclk);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(a, 1'b1, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        wb(a, 1'b0, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    // Handshake code and running count after a transfer
    task automatic hs_chk(input logic [1:0] c, input int inc);
        hs_n += inc;
        chk({30'h0, i_host.last_hs}, {30'h0, c});
        chk(i_host.hs_cnt, hs_n);
    endtask
    function automatic logic [6:0] port_of(input logic [7:0] a);
        case (a)
            ADR_IN_MAX: return in_max_bytes;
            ADR_OUT_MAX: return out_max_bytes;
            ADR_EP0_MAX: return {2'b00, ep0_max_bytes};
            ADR_SYS_CTRL: return {5'h00, usb_rst_n, usb_clk_en};
            default: return 7'h00;
        endcase
    endfunction
    // ==========================================================
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        // Reset state of registers and outputs
        for (int a = 0; a <= 'h28; a += 4) begin
            if (a != 'h24) rd_chk(8'(a), 8'h00);
        end
        chk({usb_rst_n, usb_clk_en, irq, ep0_max_bytes}, EP0_SMALL);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd_chk(rows[i].a, rows[i].r);
            chk(port_of(rows[i].a), rows[i].p);
        end
        $display("test table done");
        // Good packet, count, pops, then NAK while ready is still set
        wr(ADR_OUT_MAX, 8'h01);
        wr(ADR_INT_EN, 8'h0F);
        i_host.send(3, 8'hA0, 1'b0, 1'b0);
        hs_chk(HS_ACK, 1);
        rd_chk(ADR_OUT_CSR, 8'h01);
        rd_chk(ADR_RX_COUNT, 8'h03);
        chk(irq, 1'b1);
        for (int i = 0; i < 3; i++) rd_chk(ADR_DATA_PORT, 8'hA0 + 8'(i));
        i_host.send(2, 8'hB0, 1'b0, 1'b0);
        hs_chk(HS_NAK, 1);
        wr(ADR_OUT_CSR, 8'h00);
        rd_chk(ADR_RX_COUNT, 8'h00);
        rd_chk(ADR_INT_STAT, 8'h01);
        wr(ADR_INT_CLR, 8'h0F);
        chk(irq, 1'b0);
        $display("test packet done");
        // Oversize by one byte, then a protocol fault
        i_host.send(9, 8'h00, 1'b0, 1'b0);
        hs_chk(HS_STALL, 1);
        rd_chk(ADR_OUT_CSR, 8'h10);
        wr(ADR_OUT_CSR, 8'h00);
        i_host.send(2, 8'h00, 1'b0, 1'b1);
        hs_chk(HS_STALL, 1);
        rd_chk(ADR_OUT_CSR, 8'h10);
        wr(ADR_OUT_CSR, 8'h00);
        wr(ADR_INT_CLR, 8'h0F);
        // Firmware stall request answers the token; once cleared, a bad bulk packet gets none
        wr(ADR_OUT_CSR, 8'h04);
        i_host.send(1, 8'h00, 1'b0, 1'b0);
        hs_chk(HS_STALL, 1);
        rd_chk(ADR_OUT_CSR, 8'h04);
        wr(ADR_OUT_CSR, 8'h00);
        i_host.send(2, 8'hE0, 1'b1, 1'b0);
        hs_chk(HS_STALL, 0);
        rd_chk(ADR_OUT_CSR, 8'h00);
        $display("test stall done");
        // Isochronous: bad packet kept, overrun, then flush
        wr(ADR_OUT_CSR, 8'h08);
        i_host.send(2, 8'hC0, 1'b1, 1'b0);
        hs_chk(HS_STALL, 0);
        rd_chk(ADR_OUT_CSR, 8'h29);
        i_host.send(2, 8'hD0, 1'b0, 1'b0);
        rd_chk(ADR_OUT_CSR, 8'h2B);
        rd_chk(ADR_RX_COUNT, 8'h02);
        wr(ADR_OUT_CSR, 8'h6B);
        rd_chk(ADR_OUT_CSR, 8'h2A);
        rd_chk(ADR_RX_COUNT, 8'h00);
        wr(ADR_OUT_CSR, 8'h00);
        $display("test iso done");
        // Control endpoint turns round after an IN setup
        i_host.ep0_byte(8'h3A);
        rd_chk(ADR_EP0_PORT, 8'h3A);
        chk(ep0_dir_in, 1'b0);
        i_host.ep0_in_stage();
        chk(ep0_dir_in, 1'b1);
        wr(ADR_EP0_PORT, 8'h5A);
        repeat (3) @(posedge mclk);
        chk(i_host.last_tx, 9'h15A);
        wr(ADR_DATA_PORT, 8'hC3);
        repeat (3) @(posedge mclk);
        chk(i_host.last_tx, 9'h0C3);
        chk(i_host.tx_cnt, 2);
        $display("test ep0 done");
        stop_test();
    end
endmodule

// ### usb_ep_ctrl.sv
module usb_ep_ctrl
    import usb_ep_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic mclk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    // Receive side of the serial engine
    input wire logic out_token,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_done,
    input wire logic rx_bad,
    input wire logic proto_err,
    input wire logic ep0_rx_valid,
    input wire logic ep0_setup,
    input wire logic ep0_data_in,
    // Handshake and transmit toward the engine
    output logic hs_valid,
    output logic [1:0] hs_code,
    output logic tx_valid,
    output logic tx_ep0,
    output logic [7:0] tx_byte,
    output logic ep0_dir_in,
    // Configuration toward the USB module
    output logic [6:0] in_max_bytes,
    output logic [6:0] out_max_bytes,
    output logic [4:0] ep0_max_bytes,
    output logic usb_clk_en,
    output logic usb_rst_n
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // State
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_DROP} rx_t;

    typedef struct packed {
        logic ack;            // Bus answer
        logic [7:0] rdat;     // Read data latch
        logic [7:0] csr;      // Endpoint control/status
        logic [3:0] in_max;   // IN size code
        logic [3:0] out_max;  // OUT size code
        logic ep0_big;        // Endpoint 0 size select
        logic [1:0] sys;      // Clock gate, reset release
        logic [3:0] ist;      // Sticky events
        logic [3:0] ien;      // Event enables
        logic dir_in;         // Endpoint 0 direction
        logic [7:0] ep0_hold; // Last endpoint 0 byte
        rx_t st;              // Receive sequencer
        logic [AW-1:0] wptr;  // FIFO write pointer
        logic [AW-1:0] rptr;  // FIFO read pointer
        logic [7:0] cnt;      // Bytes of packet
        logic hs_v;
        logic [1:0] hs_c;
        logic tx_v;
        logic tx_e0;
        logic [7:0] tx_b;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic [7:0] mem [DEPTH];  // OUT FIFO storage
    logic mem_we;             // FIFO write strobe
    logic acc;                // New bus request
    logic wr;                 // Bus write at ack edge
    logic rd;                 // Bus read at ack edge
    logic [7:0] lim;          // OUT byte limit
    logic [3:0] ev;           // Events this cycle

    // Code to byte count; codes above 64 bytes clamp there
    function automatic logic [6:0] code_bytes(logic [3:0] c);
        logic [3:0] k;
        k = (c > MAX_CODE) ? MAX_CODE : c;
        return {k, 3'b000};
    endfunction

    // ==========================================================
    // Bus handshake
    // Ack is registered, so it drops the cycle after it rose
    assign acc = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    // Writes and pops happen at the edge the master sees ack
    assign wr = s_ff.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
    assign rd = s_ff.ack & wb_cyc_i & wb_stb_i & ~wb_we_i;
    assign lim = {1'b0, code_bytes(s_ff.out_max)}; // R11

    // ==========================================================
    // Next state
    always_comb begin
        nxt_s = s_ff;
        ev = 4'h0;
        mem_we = 1'b0;
        nxt_s.ack = acc;
        nxt_s.hs_v = 1'b0;
        nxt_s.tx_v = 1'b0;

        // Read data is captured when the request arrives
        if (acc) begin
            case (wb_adr_i)
                ADR_OUT_CSR: nxt_s.rdat = s_ff.csr;
                ADR_IN_MAX: nxt_s.rdat = {4'h0, s_ff.in_max};
                ADR_OUT_MAX: nxt_s.rdat = {4'h0, s_ff.out_max};
                ADR_EP0_MAX: nxt_s.rdat = {7'h00, s_ff.ep0_big};
                // Count only means something while data waits
                ADR_RX_COUNT: begin
                    nxt_s.rdat = s_ff.csr[B_RDY] ? s_ff.cnt : RST_BYTE; // R13
                end
                ADR_EP0_PORT: nxt_s.rdat = s_ff.ep0_hold;
                // Port reads zero while no packet is ready, not stale storage
                ADR_DATA_PORT: begin
                    nxt_s.rdat = s_ff.csr[B_RDY] ? mem[s_ff.rptr]
                        : RST_BYTE; // R15
                end
                ADR_SYS_CTRL: nxt_s.rdat = {6'h00, s_ff.sys};
                ADR_INT_STAT: nxt_s.rdat = {4'h0, s_ff.ist};
                ADR_INT_EN: nxt_s.rdat = {4'h0, s_ff.ien};
                // Unmapped and write-only words read zero
                default: nxt_s.rdat = RST_BYTE;
            endcase
        end

        // Pop a received byte as firmware reads the port; a read
        // with no packet waiting leaves the pointer alone
        if (rd && wb_adr_i == ADR_DATA_PORT && s_ff.csr[B_RDY]) begin
            nxt_s.rptr = s_ff.rptr + 1'b1; // R15
        end

        // Register writes; hardware events below win
        if (wr) begin
            case (wb_adr_i)
                ADR_OUT_CSR: begin
                    // Flag bits clear by writing zero; flush also clears ready
                    nxt_s.csr[B_RDY] = s_ff.csr[B_RDY] & wb_dat_i[B_RDY]; // R02
                    nxt_s.csr[B_OVR] = s_ff.csr[B_OVR] & wb_dat_i[B_OVR];
                    nxt_s.csr[B_STALL_END] = s_ff.csr[B_STALL_END]
                        & wb_dat_i[B_STALL_END];
                    nxt_s.csr[B_RX_ERR] = s_ff.csr[B_RX_ERR]
                        & wb_dat_i[B_RX_ERR];
                    // Same access may clear ready and raise stall
                    nxt_s.csr[B_STALL_REQ] = wb_dat_i[B_STALL_REQ]; // R05
                    nxt_s.csr[B_ISO] = wb_dat_i[B_ISO]; // R07
                    // Flush drops the packet and empties the FIFO
                    if (wb_dat_i[B_FLUSH]) begin
                        nxt_s.csr[B_RDY] = 1'b0; // R09
                        nxt_s.wptr = '0;
                        nxt_s.rptr = '0;
                        nxt_s.cnt = RST_BYTE;
                    end
                end
                ADR_IN_MAX: nxt_s.in_max = wb_dat_i[3:0]; // R10
                ADR_OUT_MAX: nxt_s.out_max = wb_dat_i[3:0]; // R11
                ADR_EP0_MAX: nxt_s.ep0_big = wb_dat_i[0]; // R12
                // Outgoing bytes leave at once, no buffering here
                ADR_DATA_PORT: begin
                    nxt_s.tx_v = 1'b1; // R15
                    nxt_s.tx_e0 = 1'b0;
                    nxt_s.tx_b = wb_dat_i[7:0];
                end
                // Endpoint 0 takes writes only while it faces IN
                ADR_EP0_PORT: begin
                    if (s_ff.dir_in) begin
                        nxt_s.tx_v = 1'b1; // R14
                        nxt_s.tx_e0 = 1'b1;
                        nxt_s.tx_b = wb_dat_i[7:0];
                    end
                end
                ADR_SYS_CTRL: nxt_s.sys = wb_dat_i[1:0]; // R16 R17
                ADR_INT_CLR: nxt_s.ist = s_ff.ist & ~wb_dat_i[3:0];
                ADR_INT_EN: nxt_s.ien = wb_dat_i[3:0];
                default: ;
            endcase
        end

        // Endpoint 0 direction follows the decoded setup
        if (ep0_setup) begin
            nxt_s.dir_in = 1'b0; // R14
        end
        if (ep0_data_in) begin
            nxt_s.dir_in = 1'b1; // R14
        end
        if (ep0_rx_valid && !s_ff.dir_in) begin
            nxt_s.ep0_hold = rx_byte;
        end

        // Receive sequencer for the OUT endpoint
        case (s_ff.st)
            RX_IDLE: begin
                if (out_token) begin
                    if (s_ff.csr[B_STALL_REQ]) begin
                        // Firmware stall: refuse and drain the data
                        nxt_s.hs_v = 1'b1; // R04
                        nxt_s.hs_c = HS_STALL;
                        nxt_s.st = RX_DROP;
                    end else if (s_ff.csr[B_RDY]) begin
                        nxt_s.st = RX_DROP;
                        if (s_ff.csr[B_ISO]) begin
                            // Lost iso packet is only reported
                            nxt_s.csr[B_OVR] = 1'b1; // R03
                            ev[I_OVR] = 1'b1;
                        end else begin
                            nxt_s.hs_v = 1'b1;
                            nxt_s.hs_c = HS_NAK;
                        end
                    end else begin
                        nxt_s.st = RX_DATA;
                        nxt_s.wptr = '0;
                        nxt_s.rptr = '0;
                        nxt_s.cnt = RST_BYTE;
                    end
                end
            end
            RX_DATA: begin
                if (proto_err) begin
                    nxt_s.hs_v = 1'b1; // R06
                    nxt_s.hs_c = HS_STALL;
                    nxt_s.csr[B_STALL_END] = 1'b1;
                    ev[I_STALL] = 1'b1;
                    nxt_s.st = RX_DROP;
                end else if (rx_valid && s_ff.cnt == lim) begin
                    // One byte past the limit: oversize packet
                    nxt_s.hs_v = 1'b1; // R06
                    nxt_s.hs_c = HS_STALL;
                    nxt_s.csr[B_STALL_END] = 1'b1;
                    ev[I_STALL] = 1'b1;
                    nxt_s.st = RX_DROP;
                end else if (rx_valid) begin
                    mem_we = 1'b1;
                    nxt_s.wptr = s_ff.wptr + 1'b1;
                    nxt_s.cnt = s_ff.cnt + 8'h01;
                end else if (rx_done) begin
                    nxt_s.st = RX_IDLE;
                    if (s_ff.csr[B_ISO]) begin
                        // Iso keeps damaged data, flags it
                        nxt_s.csr[B_RDY] = 1'b1; // R08
                        ev[I_RDY] = 1'b1;
                        if (rx_bad) begin
                            nxt_s.csr[B_RX_ERR] = 1'b1; // R08
                            ev[I_ERR] = 1'b1;
                        end
                    end else if (!rx_bad) begin
                        nxt_s.csr[B_RDY] = 1'b1; // R01
                        ev[I_RDY] = 1'b1;
                        nxt_s.hs_v = 1'b1; // R07
                        nxt_s.hs_c = HS_ACK;
                    end
                    // Damaged bulk data: silence lets host retry
                end
            end
            RX_DROP: begin
                if (rx_done || proto_err) begin
                    nxt_s.st = RX_IDLE;
                end
            end
            default: nxt_s.st = RX_IDLE;
        endcase

        // Sticky events; a set in the clear cycle survives
        nxt_s.ist = nxt_s.ist | ev;
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_ff <= '0; // R18
        end else begin
            s_ff <= nxt_s;
        end
    end

    // FIFO storage has no reset; pointers guard its contents
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[s_ff.wptr] <= rx_byte;
        end
    end

    // ==========================================================
    // Outputs
    assign wb_ack_o = s_ff.ack;
    assign wb_dat_o = {24'h000000, s_ff.rdat};
    assign irq = |(s_ff.ist & s_ff.ien);
    assign hs_valid = s_ff.hs_v;
    assign hs_code = s_ff.hs_c;
    assign tx_valid = s_ff.tx_v;
    assign tx_ep0 = s_ff.tx_e0;
    assign tx_byte = s_ff.tx_b;
    assign ep0_dir_in = s_ff.dir_in;
    assign in_max_bytes = code_bytes(s_ff.in_max); // R10
    assign out_max_bytes = code_bytes(s_ff.out_max);
    assign ep0_max_bytes = s_ff.ep0_big ? EP0_LARGE : EP0_SMALL; // R12
    // Gate and reset stay off until firmware enables them
    assign usb_clk_en = s_ff.sys[B_CLK_GATE]; // R17
    assign usb_rst_n = s_ff.sys[B_RST_REL]; // R16

    // ==========================================================
    // Checks
    // All checks sleep while reset is high
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Token met by an idle sequencer, and a clean packet end
    sequence tok_idle;
        out_token && s_ff.st == RX_IDLE;
    endsequence
    sequence good_end;
        s_ff.st == RX_DATA && rx_done && !rx_valid && !proto_err;
    endsequence

    ack_once_a: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");
    stall_ans_a: assert property ( // R04
        tok_idle and s_ff.csr[B_STALL_REQ]
        |=> hs_valid && hs_code == HS_STALL)
        else $error("stall request not answered");
    overrun_a: assert property ( // R03
        tok_idle and (!s_ff.csr[B_STALL_REQ] && s_ff.csr[B_RDY]
        && s_ff.csr[B_ISO]) |=> s_ff.csr[B_OVR] && !hs_valid)
        else $error("iso overrun not flagged");
    ready_set_a: assert property ( // R01
        good_end and !rx_bad |=> s_ff.csr[B_RDY])
        else $error("packet ready not set");
    // Busy bulk endpoint refuses the token with NAK
    nak_busy_a: assert property ( // R07
        tok_idle and (!s_ff.csr[B_STALL_REQ] && s_ff.csr[B_RDY]
        && !s_ff.csr[B_ISO]) |=> hs_valid && hs_code == HS_NAK)
        else $error("busy endpoint not refused");
    // Damaged bulk data stays silent so the host retries
    bulk_bad_a: assert property ( // R01
        good_end and (rx_bad && !s_ff.csr[B_ISO])
        |=> !hs_valid && !s_ff.csr[B_RDY])
        else $error("damaged bulk packet accepted");
    iso_err_a: assert property ( // R08
        good_end and (rx_bad && s_ff.csr[B_ISO])
        |=> s_ff.csr[B_RDY] && s_ff.csr[B_RX_ERR] && !hs_valid)
        else $error("iso error not flagged");
    oversize_a: assert property ( // R06
        s_ff.st == RX_DATA && rx_valid && !proto_err && s_ff.cnt == lim
        |=> hs_code == HS_STALL && s_ff.csr[B_STALL_END] ##1 !hs_valid)
        else $error("oversize packet not stalled");
    flush_a: assert property ( // R09
        wr && wb_adr_i == ADR_OUT_CSR && wb_dat_i[B_FLUSH]
        && s_ff.st != RX_DATA |=> !s_ff.csr[B_RDY] && s_ff.cnt == 8'h00)
        else $error("flush left data");
    // Count word shows the packet length while data waits
    count_rd_a: assert property ( // R13
        acc && wb_adr_i == ADR_RX_COUNT && s_ff.csr[B_RDY]
        |=> wb_dat_o[7:0] == $past(s_ff.cnt))
        else $error("received count not shown");
    sys_ctrl_a: assert property ( // R16
        wr && wb_adr_i == ADR_SYS_CTRL
        |=> usb_rst_n == $past(wb_dat_i[B_RST_REL])
        && usb_clk_en == $past(wb_dat_i[B_CLK_GATE]))
        else $error("system control not applied");
    ep0_dir_a: assert property ( // R14
        ep0_data_in |=> ep0_dir_in)
        else $error("endpoint 0 direction not turned");
    // A setup with no IN stage turns the FIFO toward firmware
    setup_dir_a: assert property ( // R14
        ep0_setup && !ep0_data_in |=> !ep0_dir_in)
        else $error("endpoint 0 direction not reset");
endmodule

// ### usb_ep_pkg.sv
// Contract
// R01: Set packet-ready when OUT data sits in FIFO
// R02: Firmware unloads FIFO, then writes zero to clear
// R03: Iso OUT while ready still set: drop, flag overrun
// R04: Stall request set answers OUT with STALL
// R05: Firmware sets or clears stall on feature requests
// R06: Oversize or protocol fault ends OUT with STALL
// R07: Iso select makes endpoint run without handshakes; code still sends STALL on stall request, oversize or fault
// R08: Iso CRC/stuff error sets ready and error together
// R09: Firmware flush empties FIFO and clears ready
// R10: IN max packet code: eight-byte steps to 64
// R11: OUT max packet code limits received packet size
// R12: Endpoint 0 size bit: 0 is 8, 1 is 16
// R13: Byte count readable while packet-ready is set
// R14: Endpoint 0 FIFO turns toward USB after IN setup
// R15: Data endpoint byte port for reads and writes
// R16: Reset-release bit zero holds USB module in reset
// R17: Clock-gate bit 0 gates 48 MHz clock, resets 0
// R18: Control/status bit layout, all bits reset zero
package usb_ep_pkg;
    // ==========================================================
    // Register byte offsets on the bus
    localparam logic [7:0] ADR_OUT_CSR = 8'h00;
    localparam logic [7:0] ADR_IN_MAX = 8'h04;
    localparam logic [7:0] ADR_OUT_MAX = 8'h08;
    localparam logic [7:0] ADR_EP0_MAX = 8'h0C;
    localparam logic [7:0] ADR_RX_COUNT = 8'h10;
    localparam logic [7:0] ADR_EP0_PORT = 8'h14;
    localparam logic [7:0] ADR_DATA_PORT = 8'h18;
    localparam logic [7:0] ADR_SYS_CTRL = 8'h1C;
    localparam logic [7:0] ADR_INT_STAT = 8'h20;
    localparam logic [7:0] ADR_INT_CLR = 8'h24;
    localparam logic [7:0] ADR_INT_EN = 8'h28;
    // ==========================================================
    // Endpoint control/status bit positions
    localparam int B_RDY = 0;
    localparam int B_OVR = 1;
    localparam int B_STALL_REQ = 2;
    localparam int B_ISO = 3;
    localparam int B_STALL_END = 4;
    localparam int B_RX_ERR = 5;
    localparam int B_FLUSH = 6;
    // System control bit positions
    localparam int B_CLK_GATE = 0;
    localparam int B_RST_REL = 1;
    // Interrupt status bit positions
    localparam int I_RDY = 0;
    localparam int I_OVR = 1;
    localparam int I_STALL = 2;
    localparam int I_ERR = 3;
    // ==========================================================
    // Reset values and codes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [3:0] MAX_CODE = 4'h8;
    localparam logic [4:0] EP0_SMALL = 5'h08;
    localparam logic [4:0] EP0_LARGE = 5'h10;
    localparam logic [1:0] HS_ACK = 2'h1;
    localparam logic [1:0] HS_NAK = 2'h2;
    localparam logic [1:0] HS_STALL = 2'h3;
endpackage

// ### usb_host_model.sv
// ==========================================================
// Host-side serial engine stand-in: makes OUT packets, watches replies
module usb_host_model
    import usb_ep_pkg::*;
(
    input wire logic mclk,
    output logic out_token,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_done,
    output logic rx_bad,
    output logic proto_err,
    output logic ep0_rx_valid,
    output logic ep0_setup,
    output logic ep0_data_in,
    input wire logic hs_valid,
    input wire logic [1:0] hs_code,
    input wire logic tx_valid,
    input wire logic tx_ep0,
    input wire logic [7:0] tx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    int hs_cnt = 0; // Handshakes seen so far
    int tx_cnt = 0; // Transmit pulses seen so far
    logic [1:0] last_hs = 2'h0; // Code of the latest handshake
    logic [8:0] last_tx = 9'h000; // Endpoint flag and byte last sent
    initial begin
        {out_token, rx_valid, rx_done, rx_bad, proto_err} = 5'h00;
        {ep0_rx_valid, ep0_setup, ep0_data_in} = 3'h0;
        rx_byte = 8'h00;
    end
    // ==========================================================
    // Replies are one-cycle pulses; looked at mid-cycle, clear of edges
    always @(negedge mclk) begin
        if (hs_valid === 1'b1) begin
            last_hs <= hs_code;
            hs_cnt <= hs_cnt + 1;
        end
        if (tx_valid === 1'b1) begin
            last_tx <= {tx_ep0, tx_byte};
            tx_cnt <= tx_cnt + 1;
        end
    end
    // One OUT transfer: token, n bytes back to back, end or abort
    task automatic send(input int n, input logic [7:0] first,
                        input logic bad, input logic abort);
        @(posedge mclk);
        out_token <= 1'b1;
        @(posedge mclk);
        out_token <= 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_byte <= first + 8'(i);
            @(posedge mclk);
        end
        rx_valid <= 1'b0;
        // Idle data line shows no stale byte
        rx_byte <= ~rx_byte;
        if (abort) begin
            // A cut packet still closes with its end marker
            proto_err <= 1'b1;
            @(posedge mclk);
            proto_err <= 1'b0;
        end
        rx_done <= 1'b1;
        rx_bad <= bad;
        @(posedge mclk);
        {proto_err, rx_done, rx_bad} <= 3'h0;
        repeat (4) @(posedge mclk);
    endtask
    // Single byte for the control endpoint
    task automatic ep0_byte(input logic [7:0] b);
        @(posedge mclk);
        ep0_rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge mclk);
        ep0_rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
    // Setup followed by an IN data stage
    task automatic ep0_in_stage();
        @(posedge mclk);
        ep0_setup <= 1'b1;
        @(posedge mclk);
        ep0_setup <= 1'b0;
        ep0_data_in <= 1'b1;
        @(posedge mclk);
        ep0_data_in <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
endmodule
